// ### src/bsm_pkg.sv
// Contract
// - Fuses load level and both modes at reset
// - Active mode field ignores software writes
// - Sleep mode field is software writable
// - Reset request when supply below threshold
// - Continuous or periodic brief detector activation
// - Sleep entry switches to sleep mode field
// - Wake-up returns to active mode field
// - Enable bit turns the monitor on
// - Event on falling, rising or either crossing
// - Monitor off while detector disabled
// - Sampled mode evaluates monitor at samples
// - Flag set on matching crossing while enabled
// - Monitor level field picks threshold offset
// - Irq while flag and enable both set
// - No monitor irq while cpu debug-halted
// - Sleep field write needs key within four
// - Locked protected write leaves register unchanged; code still writes the sample rate bit
// - Trigger codes: below, above, cross
// - Level codes: 5, 15, 25 percent
// - Mode codes: off, continuous, sampled, wake-hold
// - Status bit one while supply below monitor
package bsm_pkg;
  localparam logic [3:0] BSM_ADR_MODE   = 4'h0;
  localparam logic [3:0] BSM_ADR_LEVEL  = 4'h1;
  localparam logic [3:0] BSM_ADR_WLVL   = 4'h8;
  localparam logic [3:0] BSM_ADR_WINT   = 4'h9;
  localparam logic [3:0] BSM_ADR_WFLAG  = 4'ha;
  localparam logic [3:0] BSM_ADR_WSTATE = 4'hb;
  // Mode encodings
  localparam logic [1:0] BSM_MODE_DIS   = 2'h0;
  localparam logic [1:0] BSM_MODE_CONT  = 2'h1;
  localparam logic [1:0] BSM_MODE_SAMP  = 2'h2;
  localparam logic [1:0] BSM_MODE_WAKE  = 2'h3;
  // Trigger encodings
  localparam logic [1:0] BSM_TRIG_BELOW = 2'h0;
  localparam logic [1:0] BSM_TRIG_ABOVE = 2'h1;
  localparam logic [1:0] BSM_TRIG_CROSS = 2'h2;
  // Field positions
  localparam int BSM_POS_SAMPLE_RATE_SELECT = 4;
  localparam int BSM_POS_ACTIVE   = 2;
  localparam int BSM_POS_TRIG     = 1;
  // Reset values
  localparam logic [1:0] BSM_RST_WLVL = 2'h0;
  localparam logic [1:0] BSM_RST_TRIG = 2'h0;
  // Protection window, in instructions (one instruction per i_instr_retire pulse)
  localparam logic [2:0] BSM_UNLOCK_WINDOW = 3'h4;
  // Sample periods: 1 kHz and 125 Hz at 25 MHz
  localparam int BSM_CLK_HZ      = 25_000_000;
  localparam int BSM_FAST_HZ     = 1000;
  localparam int BSM_SLOW_HZ     = 125;
  localparam int BSM_FAST_CYCLES = BSM_CLK_HZ / BSM_FAST_HZ;
  localparam int BSM_SLOW_CYCLES = BSM_CLK_HZ / BSM_SLOW_HZ;
  // Fuse contents
  typedef struct packed {
    logic       sample_rate_select;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] brownout_threshold_select;
  } bsm_fuse_t;
  // Analog comparator view, before synchronisation
  typedef struct packed {
    logic below_brownout;
    logic below_warning;
  } bsm_cmp_t;
endpackage

// ### src/bsm_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module bsm_ctrl #(
  parameter int FAST_CYCLES = bsm_pkg::BSM_FAST_CYCLES,
  parameter int SLOW_CYCLES = bsm_pkg::BSM_SLOW_CYCLES
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // Wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [3:0]        i_wb_adr,
  input  wire logic [7:0]        i_wb_dat,
  output logic      [7:0]        o_wb_dat,
  output logic                   o_wb_ack,
  // Fuses and cpu side
  input  wire bsm_pkg::bsm_fuse_t i_fuse,
  input  wire logic              i_unlock_key,
  input  wire logic              i_instr_retire,
  input  wire logic              i_sleep_deep,
  input  wire logic              i_debug_halt,
  // Analog side
  input  wire bsm_pkg::bsm_cmp_t i_cmp,
  output logic                   o_detector_on,
  output logic      [2:0]        o_brownout_threshold,
  output logic      [1:0]        o_warning_level,
  // Results
  output logic                   o_reset_req,
  output logic                   o_wake_hold,
  output logic                   o_irq
);
  import bsm_pkg::*;

  logic       samp_rate;
  logic [1:0] active_mode;
  logic [1:0] sleep_mode;
  logic [2:0] bo_level;
  logic [1:0] wlvl;
  logic [1:0] trig;
  logic       irq_en;
  logic       flag;
  logic       below_state;
  logic       prev_below;
  logic       fuse_loaded;
  logic [2:0] unlock_cnt;
  logic [2:0] sy_bo;
  logic [2:0] sy_w;
  logic       bo_stable;
  logic       w_stable;
  logic [22:0] samp_cnt;
  logic       sample_tick;
  logic [1:0] eff_mode;
  logic       det_en;
  logic       eval;
  logic       crossing;
  logic       bus_req;
  logic       wr;
  logic [7:0] next_rdata;

  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr      = bus_req && i_wb_we;

  // Fuse load in the first cycle after reset release
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      fuse_loaded <= 1'b0;
    else
      fuse_loaded <= 1'b1;
  end

  // Fuse-loaded fields; active mode never written by software
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      samp_rate   <= 1'b0;
      active_mode <= BSM_MODE_DIS;
      bo_level    <= 3'h0;
    end
    else if (!fuse_loaded)
    begin
      samp_rate   <= i_fuse.sample_rate_select;
      active_mode <= i_fuse.active_mode;
      bo_level    <= i_fuse.brownout_threshold_select;
    end
    else if (wr && i_wb_adr == BSM_ADR_MODE)
      samp_rate   <= i_wb_dat[BSM_POS_SAMPLE_RATE_SELECT];
  end

  // Unlock window counts retired instructions after the key
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      unlock_cnt <= 3'h0;
    else if (i_unlock_key)
      unlock_cnt <= BSM_UNLOCK_WINDOW;
    else if (unlock_cnt != 3'h0 && i_instr_retire)
      unlock_cnt <= unlock_cnt - 3'h1;
  end

  // Protected sleep mode field
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      sleep_mode <= BSM_MODE_DIS;
    else if (!fuse_loaded)
      sleep_mode <= i_fuse.sleep_mode;
    else if (wr && i_wb_adr == BSM_ADR_MODE && unlock_cnt != 3'h0)
      sleep_mode <= i_wb_dat[1:0];
  end

  // Monitor configuration registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      wlvl   <= BSM_RST_WLVL;
      trig   <= BSM_RST_TRIG;
      irq_en <= 1'b0;
    end
    else if (wr && i_wb_adr == BSM_ADR_WLVL)
      wlvl   <= i_wb_dat[1:0];
    else if (wr && i_wb_adr == BSM_ADR_WINT)
    begin
      trig   <= i_wb_dat[BSM_POS_TRIG +: 2];
      irq_en <= i_wb_dat[0];
    end
  end

  // Comparator synchronisers, three stages
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      sy_bo <= 3'h0;
      sy_w  <= 3'h0;
    end
    else
    begin
      sy_bo <= {sy_bo[1:0], i_cmp.below_brownout};
      sy_w  <= {sy_w[1:0], i_cmp.below_warning};
    end
  end

  // Accept a level once the last two stages agree
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      bo_stable <= 1'b0;
      w_stable  <= 1'b0;
    end
    else
    begin
      if (sy_bo[2] == sy_bo[1])
        bo_stable <= sy_bo[2];
      if (sy_w[2] == sy_w[1])
        w_stable <= sy_w[2];
    end
  end

  // Mode selection follows sleep state
  always_comb
  begin
    eff_mode = i_sleep_deep ? sleep_mode : active_mode;
    det_en   = fuse_loaded && eff_mode != BSM_MODE_DIS;
  end

  // Sample period counter
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      samp_cnt    <= 23'h0;
      sample_tick <= 1'b0;
    end
    else if (samp_cnt == 23'h0)
    begin
      samp_cnt    <= samp_rate ? 23'(SLOW_CYCLES - 1)
                               : 23'(FAST_CYCLES - 1);
      sample_tick <= 1'b1;
    end
    else
    begin
      samp_cnt    <= samp_cnt - 23'h1;
      sample_tick <= 1'b0;
    end
  end

  // Evaluate continuously or only at sample ticks
  always_comb
  begin
    eval = det_en && (eff_mode != BSM_MODE_SAMP || sample_tick);
    unique case (trig)
      BSM_TRIG_BELOW: crossing = w_stable && !prev_below;
      BSM_TRIG_ABOVE: crossing = !w_stable && prev_below;
      BSM_TRIG_CROSS: crossing = w_stable != prev_below;
      default:        crossing = 1'b0;
    endcase
  end

  // Detector drive to analog side
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_detector_on        <= 1'b0;
      o_brownout_threshold <= 3'h0;
      o_warning_level      <= 2'h0;
      o_wake_hold          <= 1'b0;
    end
    else
    begin
      o_detector_on        <= det_en && (eff_mode != BSM_MODE_SAMP
                                         || sample_tick);
      o_brownout_threshold <= bo_level;
      o_warning_level      <= wlvl;
      o_wake_hold          <= !i_sleep_deep
                              && active_mode == BSM_MODE_WAKE;
    end
  end

  // Brownout reset request
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_reset_req <= 1'b0;
    else
      o_reset_req <= eval && bo_stable;
  end

  // Monitor state and previous sample
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      below_state <= 1'b0;
      prev_below  <= 1'b0;
    end
    else if (eval && irq_en)
    begin
      below_state <= w_stable;
      prev_below  <= w_stable;
    end
  end

  // Flag: set wins over write-one clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      flag <= 1'b0;
    else if (eval && irq_en && crossing)
      flag <= 1'b1;
    else if (wr && i_wb_adr == BSM_ADR_WFLAG && i_wb_dat[0])
      flag <= 1'b0;
  end

  // Interrupt held off during debug halt
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_irq <= 1'b0;
    else
      o_irq <= flag && irq_en && !i_debug_halt;
  end

  // Read mux
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (i_wb_adr)
      BSM_ADR_MODE:   next_rdata = {3'h0, samp_rate, active_mode,
                                    sleep_mode};
      BSM_ADR_LEVEL:  next_rdata = {5'h0, bo_level};
      BSM_ADR_WLVL:   next_rdata = {6'h0, wlvl};
      BSM_ADR_WINT:   next_rdata = {5'h0, trig, irq_en};
      BSM_ADR_WFLAG:  next_rdata = {7'h0, flag};
      BSM_ADR_WSTATE: next_rdata = {7'h0, below_state};
      default:        next_rdata = 8'h00;
    endcase
  end

  // Wishbone answer one cycle after request
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 8'h00;
    end
    else
    begin
      o_wb_ack <= bus_req;
      o_wb_dat <= bus_req ? next_rdata : 8'h00;
    end
  end

  // Checks
  sequence key_seen_s;
    i_unlock_key;
  endsequence

  locked_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (fuse_loaded && wr && i_wb_adr == BSM_ADR_MODE && unlock_cnt == 3'h0)
    |=> $stable(sleep_mode)) else $error("locked write changed sleep");
  active_fixed_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    fuse_loaded |=> $stable(active_mode))
    else $error("active mode changed");
  key_window_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    key_seen_s |=> unlock_cnt == BSM_UNLOCK_WINDOW)
    else $error("unlock window not opened");
  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (flag && irq_en && !i_debug_halt) |=> o_irq)
    else $error("irq missing");
  debug_mask_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    $past(i_debug_halt) |-> !o_irq) else $error("irq in debug");
  reset_req_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (eval && bo_stable) |=> o_reset_req)
    else $error("reset request missing");
  monitor_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (!det_en && !flag) |=> !flag) else $error("flag set while off");
  flag_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (wr && i_wb_adr == BSM_ADR_WFLAG && i_wb_dat[0] && !(eval && irq_en))
    |=> !flag) else $error("flag not cleared");
  ack_once_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_wb_ack |=> !o_wb_ack) else $error("ack held");
endmodule // bsm_ctrl
`default_nettype wire

// ### verification/bsm_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module bsm_cpu_model
  import bsm_pkg::*;
#(
  parameter bsm_pkg::bsm_fuse_t FUSE = 8'h2a
) (
  // Clock
  input  wire logic               i_clk_sys,
  // Cpu side pulses and fuses
  output var  bsm_pkg::bsm_fuse_t o_fuse,
  output var  logic               o_unlock_key,
  output var  logic               o_instr_retire
);
  // Fuse loader holds its word steady
  initial o_fuse = FUSE;
  initial o_unlock_key = 1'b0;
  initial o_instr_retire = 1'b0;

  // Key write: one cycle pulse, then the window opens
  task automatic unlock();
    o_unlock_key <= 1'b1;
    @(posedge i_clk_sys);
    o_unlock_key <= 1'b0;
  endtask

  // Retire a run of instructions, one a cycle
  task automatic retire(input int n);
    repeat (n)
    begin
      o_instr_retire <= 1'b1;
      @(posedge i_clk_sys);
    end
    o_instr_retire <= 1'b0;
  endtask
endmodule // bsm_cpu_model
`default_nettype wire

// ### verification/brownout_supply_monitor_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module brownout_supply_monitor_ctrl_test;
  import bsm_pkg::*;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, slp = 0, dbg = 0;
  logic [3:0] adr = 4'h0;
  logic [7:0] dat = 8'h00, rdat, q;
  logic ack, det, rreq, hold, irq;
  logic [2:0] thr;
  logic [1:0] wlvl;
  bsm_fuse_t fuse;
  bsm_cmp_t cmp = 2'h0;
  logic key, ret;
  int n_errors = 0, num_checks = 0;
  int pulses;

  // Clock at 25 MHz
  always #20 clk = ~clk;

  // Fuses: continuous when awake and asleep, threshold code 2
  bsm_cpu_model #(.FUSE(8'h2a)) u_cpu (.i_clk_sys(clk), .o_fuse(fuse),
    .o_unlock_key(key), .o_instr_retire(ret));

  bsm_ctrl #(.FAST_CYCLES(8), .SLOW_CYCLES(16)) u_dut (.i_clk_sys(clk),
    .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_fuse(fuse), .i_unlock_key(key), .i_instr_retire(ret),
    .i_sleep_deep(slp), .i_debug_halt(dbg), .i_cmp(cmp),
    .o_detector_on(det), .o_brownout_threshold(thr),
    .o_warning_level(wlvl), .o_reset_req(rreq), .o_wake_hold(hold),
    .o_irq(irq));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold until ack, take data at that edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(BSM_ADR_MODE, 8'h05);
    rd(BSM_ADR_LEVEL, 8'h02);
    chk({5'h0, thr}, 8'h02);
    wb(1'b1, BSM_ADR_MODE, 8'h00);
    rd(BSM_ADR_MODE, 8'h05);
    u_cpu.unlock();
    wb(1'b1, BSM_ADR_MODE, 8'h00);
    rd(BSM_ADR_MODE, 8'h04);
    u_cpu.unlock();
    u_cpu.retire(4);
    wb(1'b1, BSM_ADR_MODE, 8'h06);
    rd(BSM_ADR_MODE, 8'h04);
    // Sleep now leaves the detector off, wake restores it
    chk({7'h0, det}, 8'h01);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h0, det}, 8'h00);
    slp <= 1'b0;
    repeat (4) @(posedge clk);
    chk({7'h0, det}, 8'h01);
    chk({7'h0, hold}, 8'h00);
    cmp.below_brownout <= 1'b1;
    repeat (8) @(posedge clk);
    chk({7'h0, rreq}, 8'h01);
    cmp.below_brownout <= 1'b0;
    repeat (8) @(posedge clk);
    chk({7'h0, rreq}, 8'h00);
    for (int l = 0; l < 3; l++)
    begin
      wb(1'b1, BSM_ADR_WLVL, 8'(l));
      chk({6'h0, wlvl}, 8'(l));
    end
    // Every trigger code against a fall and a rise
    for (int t = 0; t < 4; t++)
    begin
      wb(1'b1, BSM_ADR_WINT, 8'((t << 1) | 1));
      wb(1'b1, BSM_ADR_WFLAG, 8'h01);
      cmp.below_warning <= 1'b1;
      repeat (8) @(posedge clk);
      rd(BSM_ADR_WSTATE, 8'h01);
      rd(BSM_ADR_WFLAG, 8'((t == 0) || (t == 2)));
      chk({7'h0, irq}, 8'((t == 0) || (t == 2)));
      wb(1'b1, BSM_ADR_WFLAG, 8'h01);
      cmp.below_warning <= 1'b0;
      repeat (8) @(posedge clk);
      rd(BSM_ADR_WSTATE, 8'h00);
      rd(BSM_ADR_WFLAG, 8'((t == 1) || (t == 2)));
    end
    // Raise the flag again so that a zero write has something to keep
    wb(1'b1, BSM_ADR_WINT, 8'h05);
    cmp.below_warning <= 1'b1;
    repeat (8) @(posedge clk);
    wb(1'b1, BSM_ADR_WFLAG, 8'h00);
    rd(BSM_ADR_WFLAG, 8'h01);
    chk({7'h0, irq}, 8'h01);
    dbg <= 1'b1;
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    dbg <= 1'b0;
    wb(1'b1, BSM_ADR_WFLAG, 8'h01);
    rd(BSM_ADR_WFLAG, 8'h00);
    chk({7'h0, irq}, 8'h00);
    // Sampled sleep mode: one detector pulse per fast period
    u_cpu.unlock();
    wb(1'b1, BSM_ADR_MODE, 8'h02);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    pulses = 0;
    repeat (16)
    begin
      @(posedge clk);
      pulses += det;
    end
    chk(8'(pulses), 8'h02);
    slp <= 1'b0;
    end_sim();
  end
endmodule // brownout_supply_monitor_ctrl_test
`default_nettype wire
